/* common/avtc_pkg.sv */
// constants, field layouts and carriers for the converter and video timing control registers
// Contract
// - converter control resets 0x82, adaptive bit lowest
// - bit5 clear high threshold, set low
// - bit4 clear: gain on, reference driven
// - bit3 stops decoder clock; registers stay accessible
// - bit2 set puts luma converter asleep
// - bit1 set chroma sleep, resets asleep
// - bit0 adaptive: overflow raises reference level
// - even/odd timing registers 0x6C/0xEC, reset 0x00
// - bit7 clear 64 ticks, set one pixel
// - alternative variant: set bit gives 32 ticks
package avtc_pkg;

	localparam int          ADDR_W           = 12;
	localparam int          DATA_W           = 8;

	localparam logic [11:0] OFS_CONVERTER    = 12'h068;
	localparam logic [11:0] OFS_EVEN_TIMING  = 12'h06c;
	localparam logic [11:0] OFS_ODD_TIMING   = 12'h0ec;

	localparam logic [7:0]  CONVERTER_RESET  = 8'h82;
	localparam logic [7:0]  TIMING_RESET     = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

	localparam logic [6:0]  HORIZONTAL_RESET_PULSE_STD_TICKS = 7'h40;
	localparam logic [6:0]  HORIZONTAL_RESET_PULSE_ALT_TICKS = 7'h20;
	localparam logic [6:0]  HORIZONTAL_RESET_PULSE_PIX_TICKS = 7'h01;

	localparam logic [7:0]  REF_NOMINAL      = 8'h80;
	localparam logic [7:0]  REF_STEP         = 8'h04;
	localparam logic [7:0]  REF_MAX          = 8'hff;

	typedef struct packed {
		logic [1:0] reserved_top;
		logic       sync_threshold_low;
		logic       gain_control_disable;
		logic       clock_power_down;
		logic       luma_sleep;
		logic       chroma_sleep;
		logic       adaptive_gain_mode;
	} avtc_converter_s;

	typedef struct packed {
		logic       horizontal_reset_pulse_width_select;
		logic [4:0] reserved_mid;
		logic [1:0] vertical_filter_taps;
	} avtc_timing_s;

	typedef struct packed {
		logic [11:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} avtc_req_s;

endpackage

/* design/avtc_gain_ctrl.sv */
// reference level control for the converters, with adaptive raise on overflow
`timescale 1ns/100ps
module avtc_gain_ctrl (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       run,
	input  wire logic       gain_on,
	input  wire logic       adaptive,
	input  wire logic       overflow_event,
	// level
	output logic [7:0]      ref_level_q
);

	logic raise;

	assign raise = run && gain_on && adaptive && overflow_event;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_level_q <= avtc_pkg::REF_NOMINAL;
		end else if (!adaptive) begin
			ref_level_q <= avtc_pkg::REF_NOMINAL;
		end else if (raise) begin
			if (ref_level_q > avtc_pkg::REF_MAX - avtc_pkg::REF_STEP) begin
				ref_level_q <= avtc_pkg::REF_MAX;
			end else begin
				ref_level_q <= ref_level_q + avtc_pkg::REF_STEP;
			end
		end
	end

endmodule // avtc_gain_ctrl

/* design/avtc_horizontal_reset_pulse_gen.sv */
// horizontal reset pulse generator counting single-rate clock ticks
`timescale 1ns/100ps
module avtc_horizontal_reset_pulse_gen (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// timing
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic       line_start,
	input  wire logic [6:0] width_ticks,
	// pulse
	output logic            pulse_q
);

	logic [6:0] remain_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_q  <= 1'b0;
			remain_q <= 7'h00;
		end else if (!run) begin
			pulse_q  <= 1'b0;
			remain_q <= 7'h00;
		end else if (line_start) begin
			pulse_q  <= 1'b1;
			remain_q <= width_ticks;
		end else if (pulse_q && tick) begin
			remain_q <= remain_q - 7'h01;
			if (remain_q <= 7'h01) begin
				pulse_q <= 1'b0;
			end
		end
	end

endmodule // avtc_horizontal_reset_pulse_gen

/* design/avtc_regs.sv */
// converter control and per-field video timing control registers with their front-end controls
`timescale 1ns/100ps
module avtc_regs #(
	parameter int          SINGLE_RATE_DIV = 7,
	parameter bit          ALT_HORIZONTAL_RESET_PULSE_WIDTH = 1'b0
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// register access
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	output logic             reg_rvalid,
	// video timing
	input  wire logic        line_start,
	input  wire logic        field_odd,
	output logic             horizontal_reset_pulse,
	output logic [1:0]       vertical_filter_taps,
	// converter pins
	input  wire logic        luma_overflow,
	input  wire logic        chroma_overflow,
	output logic [7:0]       converter_reference_output,
	output logic             converter_reference_oe_n,
	output logic             sync_detector_low,
	output logic             luma_sleep,
	output logic             chroma_sleep,
	output logic             decoder_clock_enable,
	output logic             single_rate_clock
);

	avtc_pkg::avtc_req_s       req;
	avtc_pkg::avtc_converter_s conv_q;
	avtc_pkg::avtc_timing_s    even_q;
	avtc_pkg::avtc_timing_s    odd_q;
	avtc_pkg::avtc_timing_s    active_timing;
	logic [7:0]                rdata_d;
	logic [7:0]                rdata_q;
	logic                      rvalid_q;
	logic                      run;
	logic [1:0]                ovf_pin;
	logic [1:0]                ovf_s1_q;
	logic [1:0]                ovf_s2_q;
	logic [1:0]                ovf_s3_q;
	logic [1:0]                ovf_level_q;
	logic [1:0]                ovf_rise;
	logic                      overflow_event;
	logic [15:0]               div_q;
	logic                      tick_q;
	logic [6:0]                width_ticks;
	logic                      horizontal_reset_pulse_q;
	logic [7:0]                ref_level_q;
	logic                      ref_oe_n_q;
	logic                      sync_low_q;
	logic                      luma_sleep_q;
	logic                      chroma_sleep_q;
	logic                      clk_en_q;
	logic                      wr_conv;
	logic                      wr_even;
	logic                      wr_odd;
	logic                      gain_on;
	logic                      adaptive;
	logic [1:0]                ovf_agree;
	logic                      div_last;
	logic [1:0]                taps_q;

	assign req = '{addr: reg_addr, wr: reg_wr, rd: reg_rd, wdata: reg_wdata};

	// write decode, addresses compared exactly
	assign wr_conv = req.wr && (req.addr == avtc_pkg::OFS_CONVERTER);
	assign wr_even = req.wr && (req.addr == avtc_pkg::OFS_EVEN_TIMING);
	assign wr_odd  = req.wr && (req.addr == avtc_pkg::OFS_ODD_TIMING);

	// registers run on clk, so they stay reachable while the decoder clock is off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_q <= avtc_pkg::CONVERTER_RESET;
		end else if (wr_conv) begin
			conv_q <= req.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			even_q <= avtc_pkg::TIMING_RESET;
		end else if (wr_even) begin
			even_q <= req.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			odd_q <= avtc_pkg::TIMING_RESET;
		end else if (wr_odd) begin
			odd_q <= req.wdata;
		end
	end

	// read mux; unmapped addresses return zero
	always_comb begin
		rdata_d = avtc_pkg::UNMAPPED_READ;
		case (req.addr)
			avtc_pkg::OFS_CONVERTER: begin
				rdata_d = conv_q;
			end
			avtc_pkg::OFS_EVEN_TIMING: begin
				rdata_d = even_q;
			end
			avtc_pkg::OFS_ODD_TIMING: begin
				rdata_d = odd_q;
			end
			default: begin
				rdata_d = avtc_pkg::UNMAPPED_READ;
			end
		endcase
	end

	// answer strobe: one cycle for every read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
		end
	end

	// read data holds until the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= avtc_pkg::UNMAPPED_READ;
		end else if (req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	// decoder clock gate: every decoder-side counter halts while powered down
	assign run = !conv_q.clock_power_down;

	// overflow pins cross in through three flops; a rise counts when stages two and three agree
	assign ovf_pin = {chroma_overflow, luma_overflow};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ovf_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ovf_s1_q[g] <= 1'b0;
					ovf_s2_q[g] <= 1'b0;
					ovf_s3_q[g] <= 1'b0;
				end else begin
					ovf_s1_q[g] <= ovf_pin[g];
					ovf_s2_q[g] <= ovf_s1_q[g];
					ovf_s3_q[g] <= ovf_s2_q[g];
				end
			end
			assign ovf_agree[g] = (ovf_s2_q[g] == ovf_s3_q[g]);
			// settled level only moves when stages two and three agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					ovf_level_q[g] <= 1'b0;
				end else if (ovf_agree[g]) begin
					ovf_level_q[g] <= ovf_s3_q[g];
				end
			end
			assign ovf_rise[g] = ovf_agree[g] && ovf_s3_q[g] && !ovf_level_q[g];
		end
	endgenerate

	assign overflow_event = |ovf_rise;

	// single-rate clock enable, stopped with the decoder clock
	assign div_last = (div_q >= 16'(SINGLE_RATE_DIV - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 16'h0000;
		end else if (!run || div_last) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// one-cycle enable pulse in the cycle after the last count of each period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= run && div_last;
		end
	end

	// field select for the timing register in use
	assign active_timing = field_odd ? odd_q : even_q;

	always_comb begin
		if (!active_timing.horizontal_reset_pulse_width_select) begin
			width_ticks = avtc_pkg::HORIZONTAL_RESET_PULSE_STD_TICKS;
		end else if (ALT_HORIZONTAL_RESET_PULSE_WIDTH) begin
			width_ticks = avtc_pkg::HORIZONTAL_RESET_PULSE_ALT_TICKS;
		end else begin
			width_ticks = avtc_pkg::HORIZONTAL_RESET_PULSE_PIX_TICKS;
		end
	end

	avtc_horizontal_reset_pulse_gen u_horizontal_reset_pulse (
		.clk         (clk),
		.rst_n       (rst_n),
		.run         (run),
		.tick        (tick_q),
		.line_start  (line_start),
		.width_ticks (width_ticks),
		.pulse_q     (horizontal_reset_pulse_q)
	);

	// gain control bit has inverted sense: clear means on
	assign gain_on  = !conv_q.gain_control_disable;
	assign adaptive = conv_q.adaptive_gain_mode;

	avtc_gain_ctrl u_gain (
		.clk            (clk),
		.rst_n          (rst_n),
		.run            (run),
		.gain_on        (gain_on),
		.adaptive       (adaptive),
		.overflow_event (overflow_event),
		.ref_level_q    (ref_level_q)
	);

	// reference pin: driven only while gain control is on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_oe_n_q <= 1'b1;
		end else begin
			ref_oe_n_q <= conv_q.gain_control_disable;
		end
	end

	// registered front-end controls, one flop per pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_low_q <= 1'b0;
		end else begin
			sync_low_q <= conv_q.sync_threshold_low;
		end
	end

	// a set sleep bit powers its converter down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			luma_sleep_q <= 1'b0;
		end else begin
			luma_sleep_q <= conv_q.luma_sleep;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chroma_sleep_q <= 1'b0;
		end else begin
			chroma_sleep_q <= conv_q.chroma_sleep;
		end
	end

	// clock enable pin is the inverse of the power-down bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_en_q <= 1'b0;
		end else begin
			clk_en_q <= run;
		end
	end

	// filter taps follow the field in use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			taps_q <= 2'b00;
		end else begin
			taps_q <= active_timing.vertical_filter_taps;
		end
	end

	assign converter_reference_output = ref_level_q;
	assign converter_reference_oe_n   = ref_oe_n_q;
	assign sync_detector_low          = sync_low_q;
	assign luma_sleep                 = luma_sleep_q;
	assign chroma_sleep               = chroma_sleep_q;
	assign decoder_clock_enable       = clk_en_q;
	assign single_rate_clock          = tick_q;
	assign horizontal_reset_pulse     = horizontal_reset_pulse_q;
	assign vertical_filter_taps       = taps_q;

endmodule // avtc_regs

/* tb/avtc_regs_asserts.sv */
// concurrent checks on the converter and timing control register ports
`timescale 1ns/100ps
module avtc_regs_asserts #(
	parameter int SINGLE_RATE_DIV  = 7,
	parameter bit ALT_HORIZONTAL_RESET_PULSE_WIDTH = 1'b0
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// register access
	input wire logic [11:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	// line start input and outputs under watch
	input wire logic        line_start,
	input wire logic        horizontal_reset_pulse,
	input wire logic        converter_reference_oe_n,
	input wire logic        sync_detector_low,
	input wire logic        luma_sleep,
	input wire logic        chroma_sleep,
	input wire logic        decoder_clock_enable,
	input wire logic        single_rate_clock
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire conv_wr = reg_wr && reg_addr == 12'h068;
	wire mapped  = reg_addr == 12'h068 || reg_addr == 12'h06c || reg_addr == 12'h0ec;

	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read without answer");
	a_no_spurious: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without read");
	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_sync_level: assert property (conv_wr |-> ##2 sync_detector_low == $past(reg_wdata[5], 2))
		else $error("sync threshold wrong");
	a_gain_pin: assert property (conv_wr |-> ##2 converter_reference_oe_n == $past(reg_wdata[4], 2))
		else $error("reference drive wrong");
	a_clock_stop: assert property (conv_wr |-> ##2 decoder_clock_enable == !$past(reg_wdata[3], 2))
		else $error("decoder clock wrong");
	a_luma_sleep: assert property (conv_wr |-> ##2 luma_sleep == $past(reg_wdata[2], 2))
		else $error("luma sleep wrong");
	a_chroma_sleep: assert property (conv_wr |-> ##2 chroma_sleep == $past(reg_wdata[1], 2))
		else $error("chroma sleep wrong");
	a_pulse_start: assert property (line_start && decoder_clock_enable && $past(decoder_clock_enable)
		|=> horizontal_reset_pulse)
		else $error("pulse did not start");
	a_quiet_asleep: assert property (!decoder_clock_enable && !$past(decoder_clock_enable)
		|-> !horizontal_reset_pulse && !single_rate_clock)
		else $error("activity while clock stopped");

	c_read: cover property (reg_rd ##1 reg_rvalid);
	c_pulse: cover property (line_start ##1 horizontal_reset_pulse);
	c_sleep: cover property (!decoder_clock_enable ##1 reg_rvalid);
endmodule // avtc_regs_asserts

bind avtc_regs avtc_regs_asserts #(.SINGLE_RATE_DIV(SINGLE_RATE_DIV), .ALT_HORIZONTAL_RESET_PULSE_WIDTH(ALT_HORIZONTAL_RESET_PULSE_WIDTH)) u_chk (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .line_start(line_start),
	.horizontal_reset_pulse(horizontal_reset_pulse), .converter_reference_oe_n(converter_reference_oe_n),
	.sync_detector_low(sync_detector_low), .luma_sleep(luma_sleep), .chroma_sleep(chroma_sleep),
	.decoder_clock_enable(decoder_clock_enable), .single_rate_clock(single_rate_clock));

/* tb/tb_avtc_regs.sv */
// self-checking bench for the converter and timing control registers
`timescale 1ns/100ps
module tb_avtc_regs;
	logic        clk, rst_n, reg_wr, reg_rd, line_start, field_odd;
	logic        luma_overflow, chroma_overflow, reg_rvalid, horizontal_reset_pulse;
	logic        converter_reference_oe_n, sync_detector_low, luma_sleep, chroma_sleep;
	logic        decoder_clock_enable, single_rate_clock, horizontal_reset_pulse_alt;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, converter_reference_output;
	logic [1:0]  vertical_filter_taps;
	int          fail_count, checks_done, cycles;

	avtc_regs #(.SINGLE_RATE_DIV(7), .ALT_HORIZONTAL_RESET_PULSE_WIDTH(1'b0)) u_dut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.line_start(line_start), .field_odd(field_odd), .horizontal_reset_pulse(horizontal_reset_pulse),
		.vertical_filter_taps(vertical_filter_taps), .luma_overflow(luma_overflow),
		.chroma_overflow(chroma_overflow), .converter_reference_output(converter_reference_output),
		.converter_reference_oe_n(converter_reference_oe_n), .sync_detector_low(sync_detector_low),
		.luma_sleep(luma_sleep), .chroma_sleep(chroma_sleep),
		.decoder_clock_enable(decoder_clock_enable), .single_rate_clock(single_rate_clock));

	// second copy with the alternative pulse width, sharing every input
	avtc_regs #(.SINGLE_RATE_DIV(7), .ALT_HORIZONTAL_RESET_PULSE_WIDTH(1'b1)) u_dut_alt (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(), .reg_rvalid(),
		.line_start(line_start), .field_odd(field_odd), .horizontal_reset_pulse(horizontal_reset_pulse_alt),
		.vertical_filter_taps(), .luma_overflow(luma_overflow),
		.chroma_overflow(chroma_overflow), .converter_reference_output(),
		.converter_reference_oe_n(), .sync_detector_low(),
		.luma_sleep(), .chroma_sleep(), .decoder_clock_enable(), .single_rate_clock());

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		// idle edge keeps back-to-back strobes apart
		step(1);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		chk({7'h00, reg_rvalid}, 8'h01);
		chk(reg_rdata, exp);
		step(1);
	endtask

	// converter control outputs gathered into register bit order, bit0 has no pin
	function automatic logic [7:0] conv_pins();
		return {2'b10, sync_detector_low, converter_reference_oe_n, ~decoder_clock_enable,
			luma_sleep, chroma_sleep, 1'b0};
	endfunction

	task automatic t_reset_values();
		rd(12'h068, 8'h82);
		rd(12'h06c, 8'h00);
		rd(12'h0ec, 8'h00);
		chk(conv_pins(), 8'h82);
	endtask

	task automatic t_read_write();
		wr(12'h06c, 8'ha5);
		rd(12'h06c, 8'ha5);
		wr(12'h0ec, 8'h3c);
		rd(12'h0ec, 8'h3c);
		rd(12'h06c, 8'ha5);
		wr(12'h070, 8'hff);
		rd(12'h070, 8'h00);
		rd(12'h068, 8'h82);
	endtask

	task automatic t_converter_bits();
		for (int i = 1; i < 6; i++) begin
			wr(12'h068, 8'h80 | (8'h01 << i));
			step(2);
			chk(conv_pins(), 8'h80 | (8'h01 << i));
			if (i == 3) begin
				wr(12'h0ec, 8'h5a);
				rd(12'h0ec, 8'h5a);
				line_start = 1'b1;
				step(1);
				line_start = 1'b0;
				step(1);
				chk({7'h00, horizontal_reset_pulse}, 8'h00);
			end
		end
		wr(12'h068, 8'h80);
		rd(12'h068, 8'h80);
	endtask

	task automatic t_horizontal_reset_pulse(input logic odd, input int n, input int n_alt, input logic [1:0] taps);
		int ticks;
		int ticks_alt;
		int k;
		ticks = 0;
		ticks_alt = 0;
		k = 0;
		field_odd = odd;
		line_start = 1'b1;
		step(1);
		line_start = 1'b0;
		while ((horizontal_reset_pulse === 1'b1 || horizontal_reset_pulse_alt === 1'b1) && k < 2000) begin
			if (single_rate_clock === 1'b1 && horizontal_reset_pulse === 1'b1)
				ticks++;
			if (single_rate_clock === 1'b1 && horizontal_reset_pulse_alt === 1'b1)
				ticks_alt++;
			step(1);
			k++;
		end
		chk(8'(ticks), 8'(n));
		chk(8'(ticks_alt), 8'(n_alt));
		chk({6'h00, vertical_filter_taps}, {6'h00, taps});
	endtask

	task automatic t_overflow(input logic chroma, input logic [7:0] exp);
		luma_overflow = !chroma;
		chroma_overflow = chroma;
		step(6);
		luma_overflow = 1'b0;
		chroma_overflow = 1'b0;
		step(6);
		chk(converter_reference_output, exp);
	endtask

	initial begin
		{rst_n, reg_wr, reg_rd, line_start, field_odd, luma_overflow, chroma_overflow} = '0;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		step(3);
		rst_n = 1'b1;
		t_reset_values();
		t_read_write();
		t_converter_bits();
		wr(12'h06c, 8'h02);
		wr(12'h0ec, 8'h83);
		step(2);
		t_horizontal_reset_pulse(1'b0, 64, 64, 2'd2);
		t_horizontal_reset_pulse(1'b1, 1, 32, 2'd3);
		wr(12'h068, 8'h81);
		step(2);
		t_overflow(1'b0, 8'h84);
		t_overflow(1'b1, 8'h88);
		wr(12'h068, 8'h80);
		step(3);
		chk(converter_reference_output, 8'h80);
		t_overflow(1'b0, 8'h80);
		report_and_stop();
	end
endmodule // tb_avtc_regs
